// file: core/bcfg_device.sv
/*
 Configuration slave: two-wire protocol engine and the register bank
 with stored and working copies of ten settings plus a control word.
 Assumes the link wires are synchronous to clk_sys.
*/
// Functional notes
// [R1] Start condition begins a new address byte
// [R2] Stop condition releases the bus
// [R3] Master sends seven address bits plus direction
// [R4] Data changes only while clock is low
// [R5] Acknowledge only a matching slave address
// [R6] Direction bit selects write or read
// [R7] Receiver acknowledges every byte; the host leaves the acknowledge bit high after the byte it reads
// [R8] Nine-clock units repeat until stop
// [R9] After stop wait for start and match
// [R10] Unmapped register reads return zero
// [R11] Stored and working copies share addresses
// [R12] Power-up loads stored copies into working
// [R13] Store bit copies ten registers over 50 ms
// [R14] No bus response during store window
// [R15] Store bit self-clears when window ends
// [R16] Setting fields right-aligned, upper bits zero
// [R17] Factory defaults and control word reset
// [R18] Address low bit comes from strap pin
// [R19] Same protocol at standard and fast rates
// [R20] Unmapped writes acknowledged and discarded
`timescale 1ns/100ps
`include "bcfg_regs.svh"
module bcfg_device
#(
	parameter int STORE_CYCLES = `BCFG_STORE_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	bcfg_link_if.device link,
	input wire logic address_strap_pin,
	output logic [79:0] setting_out,
	output logic store_busy
);
	localparam logic [79:0] NV_DEFAULTS = `BCFG_NV_DEFAULTS;
	localparam logic [39:0] WIDTHS = `BCFG_FIELD_WIDTHS;

	//------------------------------------------------------------
	// Storage
	//------------------------------------------------------------
	logic [7:0] stored_initial_copy [10];
	logic [7:0] working_setting_copy [10];
	logic [7:0] control_word;
	logic [7:0] field_mask [10];
	logic strap_taken;
	logic own_low_bit;
	logic loaded;
	logic [31:0] store_count;

	//------------------------------------------------------------
	// Protocol
	//------------------------------------------------------------
	bcfg_pkg::bcfg_slave_type state;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] shift;
	logic [3:0] bit_count;
	logic read_dir;
	logic have_pointer;
	logic [7:0] pointer;
	logic ack_ok;
	logic master_nack;
	logic [7:0] read_value;

	bcfg_edge_detect i_bcfg_edge_detect // [R19]
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.scl(link.scl),
		.sda(link.sda),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	genvar g;
	generate
		for (g = 0; g < 10; g++)
		begin : gen_field
			assign field_mask[g] = 8'((9'h001 << WIDTHS[4*(9-g) +: 4]) - 9'h001); // [R16]
			assign setting_out[8*g +: 8] = working_setting_copy[g];
		end
	endgenerate

	// Strap caught after reset release
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_taken <= 1'b0;
			own_low_bit <= 1'b0;
		end
		else if (!strap_taken)
		begin
			strap_taken <= 1'b1;
			own_low_bit <= address_strap_pin; // [R18]
		end
	end

	always_comb
	begin
		read_value = 8'h00; // [R10]
		if (pointer <= `BCFG_LAST_SETTING)
		begin
			if (control_word[`BCFG_SOURCE_BIT])
				read_value = stored_initial_copy[pointer[3:0]]; // [R11]
			else
				read_value = working_setting_copy[pointer[3:0]]; // [R11]
		end
		else if (pointer == `BCFG_CONTROL_ADDR)
			read_value = control_word;
	end

	// Stored copy: factory defaults, then store window
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 10; i++)
				stored_initial_copy[i] <= NV_DEFAULTS[8*(9-i) +: 8]; // [R17]
		end
		else if (store_busy && store_count == 32'(STORE_CYCLES - 1))
		begin
			for (int i = 0; i < 10; i++)
				stored_initial_copy[i] <= working_setting_copy[i]; // [R13]
		end
	end

	// Store window timer
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			store_busy <= 1'b0;
			store_count <= 32'h0000_0000;
		end
		else if (store_busy)
		begin
			if (store_count == 32'(STORE_CYCLES - 1))
			begin
				store_busy <= 1'b0; // [R15]
				store_count <= 32'h0000_0000;
			end
			else
				store_count <= store_count + 32'h0000_0001; // [R13]
		end
		else if (control_word[`BCFG_STORE_BIT] && state == bcfg_pkg::BCFG_IDLE)
			store_busy <= 1'b1;
	end

	// Working copy and control word
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loaded <= 1'b0;
			control_word <= `BCFG_CONTROL_RESET; // [R17]
			for (int i = 0; i < 10; i++)
				working_setting_copy[i] <= 8'h00;
		end
		else if (!loaded)
		begin
			loaded <= 1'b1;
			for (int i = 0; i < 10; i++)
				working_setting_copy[i] <= stored_initial_copy[i]; // [R12]
		end
		else
		begin
			if (store_busy && store_count == 32'(STORE_CYCLES - 1))
				control_word[`BCFG_STORE_BIT] <= 1'b0; // [R15]
			if (state == bcfg_pkg::BCFG_RECV && scl_fall && bit_count == 4'd8
				&& have_pointer)
			begin
				if (pointer <= `BCFG_LAST_SETTING)
					working_setting_copy[pointer[3:0]] <=
						shift & field_mask[pointer[3:0]]; // [R16]
				else if (pointer == `BCFG_CONTROL_ADDR)
					control_word <= shift & 8'h81;
				// Other addresses dropped // [R20]
			end
		end
	end

	// Serial engine
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= bcfg_pkg::BCFG_IDLE;
			shift <= 8'h00;
			bit_count <= 4'd0;
			read_dir <= 1'b0;
			have_pointer <= 1'b0;
			pointer <= 8'h00;
			ack_ok <= 1'b0;
			master_nack <= 1'b0;
			link.sda_dev_o <= 1'b1;
			link.sda_dev_oe <= 1'b0;
		end
		else if (store_busy || !loaded)
		begin
			state <= bcfg_pkg::BCFG_IDLE; // [R14]
			link.sda_dev_oe <= 1'b0;
		end
		else if (stop_seen)
		begin
			state <= bcfg_pkg::BCFG_IDLE; // [R2] [R9]
			link.sda_dev_oe <= 1'b0;
		end
		else if (start_seen)
		begin
			state <= bcfg_pkg::BCFG_ADDR; // [R1]
			bit_count <= 4'd0;
			have_pointer <= 1'b0;
			link.sda_dev_oe <= 1'b0;
		end
		else
		begin
			case (state)
				bcfg_pkg::BCFG_IDLE:
					link.sda_dev_oe <= 1'b0; // [R9]
				bcfg_pkg::BCFG_ADDR, bcfg_pkg::BCFG_RECV:
				begin
					if (scl_rise && bit_count < 4'd8)
					begin
						shift <= {shift[6:0], link.sda}; // [R4]
						bit_count <= bit_count + 4'd1;
					end
					else if (scl_fall && bit_count == 4'd8)
					begin
						bit_count <= 4'd0;
						if (state == bcfg_pkg::BCFG_ADDR)
						begin
							ack_ok <= shift[7:1] == {`BCFG_ADDR_HIGH, own_low_bit}; // [R3] [R5]
							read_dir <= shift[0]; // [R6]
							link.sda_dev_oe <= shift[7:1] == {`BCFG_ADDR_HIGH, own_low_bit}; // [R5]
						end
						else
						begin
							ack_ok <= 1'b1;
							link.sda_dev_oe <= 1'b1; // [R7] [R20]
							if (!have_pointer)
								have_pointer <= 1'b1;
							else
								pointer <= pointer + 8'h01;
							if (!have_pointer)
								pointer <= shift;
						end
						link.sda_dev_o <= 1'b0;
						state <= bcfg_pkg::BCFG_ACK;
					end
				end
				bcfg_pkg::BCFG_ACK:
				begin
					if (scl_fall)
					begin
						link.sda_dev_oe <= 1'b0;
						if (!ack_ok)
							state <= bcfg_pkg::BCFG_IDLE; // [R5]
						else if (read_dir)
						begin
							shift <= {read_value[6:0], 1'b0};
							link.sda_dev_o <= read_value[7];
							link.sda_dev_oe <= !read_value[7];
							bit_count <= 4'd1;
							state <= bcfg_pkg::BCFG_SEND; // [R6]
						end
						else
							state <= bcfg_pkg::BCFG_RECV; // [R8]
					end
				end
				bcfg_pkg::BCFG_SEND:
				begin
					if (scl_fall)
					begin
						if (bit_count == 4'd8)
						begin
							link.sda_dev_oe <= 1'b0;
							pointer <= pointer + 8'h01; // [R8]
							state <= bcfg_pkg::BCFG_MACK;
						end
						else
						begin
							link.sda_dev_o <= shift[7]; // [R4]
							link.sda_dev_oe <= !shift[7];
							shift <= {shift[6:0], 1'b0};
							bit_count <= bit_count + 4'd1;
						end
					end
				end
				bcfg_pkg::BCFG_MACK:
				begin
					if (scl_rise)
						master_nack <= link.sda; // [R7]
					else if (scl_fall && master_nack)
						state <= bcfg_pkg::BCFG_IDLE; // [R9]
					else if (scl_fall)
					begin
						shift <= {read_value[6:0], 1'b0};
						link.sda_dev_o <= read_value[7];
						link.sda_dev_oe <= !read_value[7];
						bit_count <= 4'd1;
						state <= bcfg_pkg::BCFG_SEND; // [R8]
					end
				end
				default:
					state <= bcfg_pkg::BCFG_IDLE;
			endcase
		end
	end
endmodule

// file: core/bcfg_regs.svh
/*
 Register offsets, field widths, reset values and timing counts of the
 bias configuration slave. Assumes a 200 MHz system clock.
*/
`ifndef BCFG_REGS_SVH
`define BCFG_REGS_SVH
`define BCFG_ADDR_HIGH 6'h10
`define BCFG_LAST_SETTING 8'h09
`define BCFG_CONTROL_ADDR 8'hff
`define BCFG_STORE_BIT 7
`define BCFG_SOURCE_BIT 0
`define BCFG_CONTROL_RESET 8'h00
`define BCFG_NV_DEFAULTS {8'h21, 8'h20, 8'h03, 8'h01, 8'h09, 8'h09, \
	8'h20, 8'h01, 8'h03, 8'h03}
`define BCFG_FIELD_WIDTHS {4'd6, 4'd6, 4'd3, 4'd4, 4'd4, 4'd4, 4'd6, \
	4'd3, 4'd3, 4'd3}
`define BCFG_CLK_MHZ 200
`define BCFG_STORE_MS 50
`define BCFG_STORE_CYCLES (`BCFG_STORE_MS * 1000 * `BCFG_CLK_MHZ)
`define BCFG_HOST_HALF_NS 1250
`define BCFG_HOST_HALF_CYCLES (`BCFG_HOST_HALF_NS * `BCFG_CLK_MHZ / 1000)
`define BCFG_HOST_CTRL 32'h0000_0000
`define BCFG_HOST_WDATA 32'h0000_0004
`define BCFG_HOST_STATUS 32'h0000_0008
`define BCFG_HOST_RDATA 32'h0000_000c
`endif

// file: core/bcfg_pkg.sv
/*
 Types shared by both ends of the bias configuration link.
 Assumes the register header is compiled alongside.
*/
package bcfg_pkg;
	typedef enum logic [5:0] {
		BCFG_IDLE = 6'b000001,
		BCFG_ADDR = 6'b000010,
		BCFG_ACK = 6'b000100,
		BCFG_RECV = 6'b001000,
		BCFG_SEND = 6'b010000,
		BCFG_MACK = 6'b100000
	} bcfg_slave_type;
	typedef enum logic [6:0] {
		BCFG_H_IDLE = 7'b0000001,
		BCFG_H_START = 7'b0000010,
		BCFG_H_BIT = 7'b0000100,
		BCFG_H_ACK = 7'b0001000,
		BCFG_H_STOP = 7'b0010000,
		BCFG_H_NEXT = 7'b0100000,
		BCFG_H_DONE = 7'b1000000
	} bcfg_host_type;
endpackage

// file: core/bcfg_link_if.sv
/*
 Two-wire link between the host controller and the configuration slave.
 Open drain: the wire is low while any party enables its output with a zero output value.
*/
`timescale 1ns/100ps
interface bcfg_link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
	modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe,
		output sda_host_o, output sda_host_oe);
endinterface

// file: core/bcfg_edge_detect.sv
/*
 Edge and bus condition detector for the two-wire link.
 Assumes scl and sda are synchronous to clk_sys.
*/
`timescale 1ns/100ps
module bcfg_edge_detect
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_seen,
	output logic stop_seen
);
	logic scl_q;
	logic sda_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	assign scl_rise = scl && !scl_q;
	assign scl_fall = !scl && scl_q;
	assign start_seen = scl && scl_q && sda_q && !sda; // [R1]
	assign stop_seen = scl && scl_q && !sda_q && sda; // [R2]
endmodule

// file: core/bcfg_host.sv
/*
 Host controller: AHB-Lite slave registers order single byte transfers
 on the two-wire link (write register, or pointer write then read).
 Assumes one AHB master and the device on the link.
*/
`timescale 1ns/100ps
`include "bcfg_regs.svh"
module bcfg_host
#(
	parameter int HALF_CYCLES = `BCFG_HOST_HALF_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	bcfg_link_if.host link,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	bcfg_pkg::bcfg_host_type state;
	logic [7:0] dev_addr;
	logic [7:0] reg_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic busy;
	logic nacked;
	logic go;
	logic is_read;
	logic [1:0] phase;
	logic [1:0] byte_idx;
	logic [3:0] bit_idx;
	logic [7:0] cur_byte;
	logic [15:0] tick_count;
	logic tick;
	logic wr_pend;
	logic [7:0] wr_addr;

	//------------------------------------------------------------
	// Bus slave
	//------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1])
				wr_addr <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite)
			begin
				case (haddr[7:0])
					8'(`BCFG_HOST_CTRL): hrdata <= {23'h0, is_read, dev_addr};
					8'(`BCFG_HOST_WDATA): hrdata <= {16'h0, reg_addr, wr_data};
					8'(`BCFG_HOST_STATUS): hrdata <= {30'h0, nacked, busy};
					8'(`BCFG_HOST_RDATA): hrdata <= {24'h0, rd_data};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dev_addr <= 8'h00;
			is_read <= 1'b0;
			reg_addr <= 8'h00;
			wr_data <= 8'h00;
			go <= 1'b0;
		end
		else
		begin
			go <= 1'b0;
			if (wr_pend && wr_addr == 8'(`BCFG_HOST_CTRL) && !busy)
			begin
				dev_addr <= hwdata[7:0];
				is_read <= hwdata[8];
				go <= hwdata[9];
			end
			if (wr_pend && wr_addr == 8'(`BCFG_HOST_WDATA) && !busy)
			begin
				wr_data <= hwdata[7:0];
				reg_addr <= hwdata[15:8];
			end
		end
	end

	// Bit timing divider
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_count <= 16'h0000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= tick_count == 16'(HALF_CYCLES - 1);
			if (tick_count == 16'(HALF_CYCLES - 1))
				tick_count <= 16'h0000;
			else
				tick_count <= tick_count + 16'h0001;
		end
	end

	//------------------------------------------------------------
	// Link sequencer
	//------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= bcfg_pkg::BCFG_H_IDLE;
			busy <= 1'b0;
			nacked <= 1'b0;
			rd_data <= 8'h00;
			phase <= 2'd0;
			byte_idx <= 2'd0;
			bit_idx <= 4'd0;
			cur_byte <= 8'h00;
			link.scl_o <= 1'b1;
			link.scl_oe <= 1'b0;
			link.sda_host_o <= 1'b1;
			link.sda_host_oe <= 1'b0;
		end
		else if (state == bcfg_pkg::BCFG_H_IDLE)
		begin
			if (go)
			begin
				busy <= 1'b1;
				nacked <= 1'b0;
				byte_idx <= 2'd0;
				phase <= 2'd0;
				cur_byte <= {dev_addr[6:0], 1'b0};
				state <= bcfg_pkg::BCFG_H_START;
			end
		end
		else if (tick)
		begin
			case (state)
				bcfg_pkg::BCFG_H_START:
				begin
					link.sda_host_oe <= 1'b1; // [R1]
					link.sda_host_o <= 1'b0;
					link.scl_oe <= phase == 2'd1;
					link.scl_o <= 1'b0;
					phase <= phase + 2'd1;
					if (phase == 2'd1)
					begin
						bit_idx <= 4'd0;
						phase <= 2'd0;
						state <= bcfg_pkg::BCFG_H_BIT;
					end
				end
				bcfg_pkg::BCFG_H_BIT, bcfg_pkg::BCFG_H_ACK:
				begin
					if (phase == 2'd0)
					begin
						link.scl_oe <= 1'b1;
						if (state == bcfg_pkg::BCFG_H_ACK)
						begin
							link.sda_host_oe <= byte_idx == 2'd3;
							link.sda_host_o <= 1'b1;
						end
						else if (byte_idx == 2'd3)
							link.sda_host_oe <= 1'b0;
						else
						begin
							link.sda_host_oe <= !cur_byte[7];
							link.sda_host_o <= cur_byte[7];
						end
						phase <= 2'd1;
					end
					else if (phase == 2'd1)
					begin
						link.scl_oe <= 1'b0;
						phase <= 2'd2;
					end
					else
					begin
						link.scl_oe <= 1'b1;
						phase <= 2'd0;
						if (state == bcfg_pkg::BCFG_H_ACK)
						begin
							if (byte_idx != 2'd3 && link.sda)
								nacked <= 1'b1;
							state <= bcfg_pkg::BCFG_H_NEXT;
						end
						else
						begin
							if (byte_idx == 2'd3)
								rd_data <= {rd_data[6:0], link.sda};
							cur_byte <= {cur_byte[6:0], 1'b0};
							bit_idx <= bit_idx + 4'd1;
							if (bit_idx == 4'd7)
								state <= bcfg_pkg::BCFG_H_ACK;
						end
					end
				end
				bcfg_pkg::BCFG_H_NEXT:
				begin
					bit_idx <= 4'd0;
					byte_idx <= byte_idx + 2'd1;
					state <= bcfg_pkg::BCFG_H_BIT;
					if (nacked || byte_idx == 2'd3 || (byte_idx == 2'd1 && is_read)
						|| (byte_idx == 2'd2 && !is_read))
						state <= bcfg_pkg::BCFG_H_STOP;
					else if (byte_idx == 2'd0)
						cur_byte <= reg_addr;
					else
						cur_byte <= wr_data;
				end
				bcfg_pkg::BCFG_H_STOP:
				begin
					link.sda_host_oe <= phase != 2'd2; // [R2]
					link.sda_host_o <= 1'b0;
					link.scl_oe <= phase == 2'd0;
					phase <= phase + 2'd1;
					if (phase == 2'd1 && is_read && byte_idx == 2'd2 && !nacked)
					begin
						phase <= 2'd0;
						link.sda_host_oe <= 1'b1;
						link.scl_oe <= 1'b1;
						link.sda_host_o <= 1'b1;
						byte_idx <= 2'd3;
						cur_byte <= {dev_addr[6:0], 1'b1};
						state <= bcfg_pkg::BCFG_H_DONE;
					end
					else if (phase == 2'd2)
					begin
						phase <= 2'd0;
						state <= bcfg_pkg::BCFG_H_DONE;
					end
				end
				bcfg_pkg::BCFG_H_DONE:
				begin
					if (byte_idx == 2'd3 && cur_byte[0])
					begin
						link.sda_host_oe <= 1'b0;
						link.scl_oe <= 1'b0;
						byte_idx <= 2'd2;
						state <= bcfg_pkg::BCFG_H_START;
					end
					else
					begin
						busy <= 1'b0;
						state <= bcfg_pkg::BCFG_H_IDLE;
					end
				end
				default:
					state <= bcfg_pkg::BCFG_H_IDLE;
			endcase
		end
	end
endmodule

// file: verification/bcfg_link_props.sv
/*
 Checker of the two-wire link between host controller and slave.
 Assumes the link wires and store_busy are synchronous to clk_sys.
*/
`timescale 1ns/100ps
module bcfg_link_props
#(
	parameter int STORE_CYCLES = 10000000
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic store_busy
);
	// ----------------
	// Helper logic
	// ----------------
	logic scl_q;
	logic sda_q;
	logic in_frame;
	logic [31:0] busy_cnt;
	wire dev_low = sda_dev_oe && !sda_dev_o;
	wire start_c = scl && scl_q && sda_q && !sda;
	wire stop_c = scl && scl_q && !sda_q && sda;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			in_frame <= 1'b0;
		else if (start_c)
			in_frame <= 1'b1;
		else if (stop_c)
			in_frame <= 1'b0;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			busy_cnt <= 32'h0000_0000;
		else if (store_busy)
			busy_cnt <= busy_cnt + 32'h0000_0001;
		else
			busy_cnt <= 32'h0000_0000;
	end
	// ----------------
	// Assertions
	// ----------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	AST_DEV_SDA_STABLE: assert property ((scl && $past(scl)) |-> $stable(dev_low))
		else $error("device data moved while clock high");
	AST_ACK_HOLD: assert property (($rose(scl) && dev_low) |=> ((dev_low || !scl) [*8]))
		else $error("device low level dropped within clock high");
	AST_START_QUIET: assert property (start_c |=> ((!dev_low) [*8]))
		else $error("device drove data right after start");
	AST_IDLE_QUIET: assert property (!in_frame |-> !dev_low)
		else $error("device drove data outside a frame");
	AST_STORE_QUIET: assert property (store_busy |-> !dev_low)
		else $error("device answered during store window");
	AST_STORE_LEN: assert property ($fell(store_busy) |->
		(busy_cnt >= STORE_CYCLES - 1 && busy_cnt <= STORE_CYCLES + 1))
		else $error("store window length wrong");
	AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> (scl [*8]))
		else $error("clock high phase too short");
	AST_SCL_LOW_MIN: assert property ($fell(scl) |-> ((!scl) [*8]))
		else $error("clock low phase too short");
	cover property (start_c);
	cover property ($rose(store_busy));
	cover property ($rose(scl) && dev_low);
endmodule

// file: verification/bias_config_regs_i2c_eeprom_tb.sv
/*
 Testbench: host controller and slave joined by the link interface.
 Assumes AHB-Lite access to the host registers, strap pin driven here.
*/
`timescale 1ns/100ps
module bias_config_regs_i2c_eeprom_tb;
	localparam int STORE_N = 3000;
	localparam logic [6:0] DEV = 7'h21;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic strap = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [79:0] setting_out;
	logic store_busy;
	logic [31:0] last_status;
	logic [31:0] last_rd;
	int fail_count = 0;
	int checked = 0;
	bcfg_link_if link();
	always #2.5 clk_sys = !clk_sys;
	bcfg_device #(.STORE_CYCLES(STORE_N)) i_bcfg_device (.clk_sys(clk_sys),
		.rst_n(rst_n), .link(link.device), .address_strap_pin(strap),
		.setting_out(setting_out), .store_busy(store_busy));
	bcfg_host #(.HALF_CYCLES(50)) i_bcfg_host (.clk_sys(clk_sys),
		.rst_n(rst_n), .link(link.host), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp));
	bcfg_link_props #(.STORE_CYCLES(STORE_N)) i_bcfg_link_props (
		.clk_sys(clk_sys), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
		.sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
		.store_busy(store_busy));
	// ----------------
	// Tasks
	// ----------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string name, input logic [79:0] seen,
		input logic [79:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic edge_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64)
		begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] addr,
		input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= addr;
		hwrite <= wr;
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wdata;
		edge_ready();
		rdata = hrdata;
	endtask
	task automatic link_op(input logic rd_op, input logic [6:0] dev,
		input logic [7:0] reg_a, input logic [7:0] data);
		logic [31:0] s;
		int n;
		ahb(1'b1, 32'h0000_0004, {16'h0000, reg_a, data}, s);
		ahb(1'b1, 32'h0000_0000, {22'h00_0000, 1'b1, rd_op, 1'b0, dev}, s);
		n = 0;
		do
		begin
			repeat (20) @(posedge clk_sys);
			ahb(1'b0, 32'h0000_0008, 32'h0000_0000, s);
			n++;
		end
		while (s[0] !== 1'b0 && n < 1000);
		if (n >= 1000)
		begin
			fail_count++;
			end_of_test();
		end
		last_status = s;
		if (rd_op)
			ahb(1'b0, 32'h0000_000c, 32'h0000_0000, last_rd);
	endtask
	task automatic wait_busy(input logic level, input int limit);
		int n;
		n = 0;
		while (store_busy !== level && n < limit)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= limit)
		begin
			fail_count++;
			end_of_test();
		end
	endtask
	// ----------------
	// Tests
	// ----------------
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check("settings", setting_out, 80'h0303_0120_0909_0103_2021);
		link_op(1'b1, DEV, 8'hff, 8'h00);
		check("control", last_rd[7:0], 8'h00);
		$display("test defaults done");
		link_op(1'b0, DEV, 8'h00, 8'hff);
		link_op(1'b0, DEV, 8'h02, 8'hff);
		link_op(1'b0, DEV, 8'h03, 8'hff);
		check("masked", setting_out[31:0], 32'h0f07_203f);
		link_op(1'b1, DEV, 8'h00, 8'h00);
		check("readback", last_rd[7:0], 8'h3f);
		check("read ack", last_status[1], 1'b0);
		$display("test write read done");
		link_op(1'b0, DEV, 8'h20, 8'h55);
		check("unmapped ack", last_status[1], 1'b0);
		check("unmapped keep", setting_out, 80'h0303_0120_0909_0f07_203f);
		link_op(1'b1, DEV, 8'h20, 8'h00);
		check("unmapped read", last_rd[7:0], 8'h00);
		$display("test unmapped done");
		link_op(1'b0, 7'h20, 8'h00, 8'h11);
		check("foreign nack", last_status[1], 1'b1);
		check("foreign keep", setting_out[7:0], 8'h3f);
		link_op(1'b0, DEV, 8'h01, 8'h25);
		check("fresh start", setting_out[15:8], 8'h25);
		$display("test address done");
		link_op(1'b0, DEV, 8'hff, 8'h80);
		wait_busy(1'b1, 200);
		check("store busy", store_busy, 1'b1);
		link_op(1'b0, DEV, 8'h01, 8'h11);
		check("store nack", last_status[1], 1'b1);
		wait_busy(1'b0, 2 * STORE_N);
		link_op(1'b1, DEV, 8'hff, 8'h00);
		check("store clear", last_rd[7:0], 8'h00);
		link_op(1'b0, DEV, 8'h00, 8'h05);
		link_op(1'b0, DEV, 8'hff, 8'h01);
		link_op(1'b1, DEV, 8'h00, 8'h00);
		check("stored copy", last_rd[7:0], 8'h3f);
		check("working copy", setting_out[15:0], 16'h2505);
		$display("test store done");
		strap <= 1'b0;
		rst_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		link_op(1'b0, 7'h20, 8'h01, 8'h11);
		check("strap ack", last_status[1], 1'b0);
		check("strap write", setting_out[15:8], 8'h11);
		link_op(1'b0, DEV, 8'h01, 8'h22);
		check("strap nack", last_status[1], 1'b1);
		check("strap keep", setting_out[15:8], 8'h11);
		$display("test strap done");
		end_of_test();
	end
endmodule
